// >>> hdl/tcpe_pkg.sv
package tcpe_pkg;
   // ============================================================
   // Register map, byte addresses
   localparam logic [11:0] OFF_EMU_RATIO = 12'h004;
   localparam logic [11:0] OFF_CNT_LO    = 12'h010;
   localparam logic [11:0] OFF_CNT_HI    = 12'h014;
   localparam logic [11:0] OFF_PRD_LO    = 12'h018;
   localparam logic [11:0] OFF_PRD_HI    = 12'h01c;
   localparam logic [11:0] OFF_CTRL      = 12'h040;

   // ============================================================
   // Field positions
   localparam int EMU_FREE_BIT    = 0;
   localparam int EMU_SOFT_BIT    = 1;
   localparam int RATIO_LSB       = 16;
   localparam int RATIO_MSB       = 19;
   localparam int CTRL_MODE_LSB   = 0;
   localparam int CTRL_LO_RS_BIT  = 2;
   localparam int CTRL_HI_RS_BIT  = 3;
   localparam int CTRL_ENA_LO_LSB = 4;
   localparam int CTRL_ENA_HI_LSB = 6;

   // ============================================================
   // Reset values and fixed figures
   localparam logic [31:0] CNT_RST     = 32'h0000_0000;
   localparam logic [31:0] PRD_RST     = 32'h0000_0000;
   localparam logic [7:0]  CTRL_RST    = 8'h00;
   localparam logic [1:0]  EMU_RST     = 2'h0;
   localparam logic [3:0]  CLOCK_RATIO = 4'h1;

   // ============================================================
   // Timer mode and enable mode codes
   localparam logic [1:0] MODE_GP64      = 2'h0;
   localparam logic [1:0] MODE_DUAL_UNCH = 2'h1;
   localparam logic [1:0] MODE_WDOG      = 2'h2;
   localparam logic [1:0] MODE_DUAL_CH   = 2'h3;
   localparam logic [1:0] ENA_OFF        = 2'h0;
   localparam logic [1:0] ENA_ONCE       = 2'h1;
   localparam logic [1:0] ENA_CONT       = 2'h2;
endpackage

// >>> hdl/tcpe_timer_regs.sv
`timescale 1ns/1ps
module tcpe_timer_regs (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        emu_suspend,
   output logic             period_match_lo,
   output logic             period_match_hi
);

   // ============================================================
   // Storage
   logic [31:0] cnt_lo_q;
   logic [31:0] cnt_lo_d;
   logic [31:0] cnt_hi_q;
   logic [31:0] cnt_hi_d;
   logic [31:0] prd_lo_q;
   logic [31:0] prd_hi_q;
   logic [7:0]  ctrl_q;
   logic [1:0]  emu_q;
   logic        done_lo_q;
   logic        done_lo_d;
   logic        done_hi_q;
   logic        done_hi_d;
   logic        match_lo_q;
   logic        match_lo_d;
   logic        match_hi_q;
   logic        match_hi_d;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic        susp_meta_q;
   logic        susp_q;
   logic [3:0]  div_q;
   logic        tick_q;

   // ============================================================
   // Bus decode
   wire         access_start = psel & penable & ~pready_q;
   wire         access_done  = psel & penable & pready_q;
   wire         hit_emu      = (paddr == tcpe_pkg::OFF_EMU_RATIO);
   wire         hit_cnt_lo   = (paddr == tcpe_pkg::OFF_CNT_LO);
   wire         hit_cnt_hi   = (paddr == tcpe_pkg::OFF_CNT_HI);
   wire         hit_prd_lo   = (paddr == tcpe_pkg::OFF_PRD_LO);
   wire         hit_prd_hi   = (paddr == tcpe_pkg::OFF_PRD_HI);
   wire         hit_ctrl     = (paddr == tcpe_pkg::OFF_CTRL);
   wire         hit_any      = hit_emu | hit_cnt_lo | hit_cnt_hi | hit_prd_lo
                               | hit_prd_hi | hit_ctrl;
   wire         wr_ok        = access_done & pwrite;
   wire         wr_emu       = wr_ok & hit_emu;
   wire         wr_cnt_lo    = wr_ok & hit_cnt_lo;
   wire         wr_cnt_hi    = wr_ok & hit_cnt_hi;
   wire         wr_prd_lo    = wr_ok & hit_prd_lo;
   wire         wr_prd_hi    = wr_ok & hit_prd_hi;
   wire         wr_ctrl      = wr_ok & hit_ctrl;

   // Only the two emulation bits are stored; the ratio and reserved bits are constants.
   wire [31:0]  emu_word     = {12'h000, tcpe_pkg::CLOCK_RATIO, 14'h0000,
                               emu_q};
   wire [31:0]  rd_mux       = hit_emu    ? emu_word :
                               hit_cnt_lo ? cnt_lo_q :
                               hit_cnt_hi ? cnt_hi_q :
                               hit_prd_lo ? prd_lo_q :
                               hit_prd_hi ? prd_hi_q :
                               hit_ctrl   ? {24'h000000, ctrl_q} : 32'h0000_0000;

   // ============================================================
   // Control fields
   wire [1:0]   mode      = ctrl_q[tcpe_pkg::CTRL_MODE_LSB +: 2];
   wire         lo_rs     = ctrl_q[tcpe_pkg::CTRL_LO_RS_BIT];
   wire         hi_rs     = ctrl_q[tcpe_pkg::CTRL_HI_RS_BIT];
   wire [1:0]   ena_lo    = ctrl_q[tcpe_pkg::CTRL_ENA_LO_LSB +: 2];
   wire [1:0]   ena_hi    = ctrl_q[tcpe_pkg::CTRL_ENA_HI_LSB +: 2];
   wire         free_run  = emu_q[tcpe_pkg::EMU_FREE_BIT];
   wire         soft_stop = emu_q[tcpe_pkg::EMU_SOFT_BIT];
   wire         is64      = (mode == tcpe_pkg::MODE_GP64)
                            | (mode == tcpe_pkg::MODE_WDOG);
   wire         chained   = (mode == tcpe_pkg::MODE_DUAL_CH);

   // ============================================================
   // Match and suspend decisions
   wire [63:0]  cnt64     = {cnt_hi_q, cnt_lo_q};
   wire [63:0]  prd64     = {prd_hi_q, prd_lo_q};
   wire         m64       = (cnt64 == prd64);
   wire         m_lo      = (cnt_lo_q == prd_lo_q);
   wire         m_hi      = (cnt_hi_q == prd_hi_q);
   wire         m_lo_sel  = is64 ? m64 : m_lo;
   // A soft stop lets the count reach its period before freezing there.
   wire         halt_lo   = susp_q & ~free_run
                            & (~soft_stop | m_lo_sel);
   wire         halt_hi   = susp_q & ~free_run & (~soft_stop | m_hi);
   wire         en_lo     = (ena_lo == tcpe_pkg::ENA_CONT)
                            | ((ena_lo == tcpe_pkg::ENA_ONCE) & ~done_lo_q);
   wire         en_hi     = (ena_hi == tcpe_pkg::ENA_CONT)
                            | ((ena_hi == tcpe_pkg::ENA_ONCE) & ~done_hi_q);
   wire         run_lo    = lo_rs & ~halt_lo & en_lo;
   wire         run_hi    = hi_rs & ~halt_hi & en_hi;
   wire         run64     = run_lo & hi_rs;
   wire         go_hi     = chained ? (run_lo & m_lo & run_hi) : run_hi;
   wire [63:0]  cnt64_inc = cnt64 + 64'h0000_0000_0000_0001;

   // ============================================================
   // Counter next state
   always_comb begin
      cnt_lo_d   = cnt_lo_q;
      cnt_hi_d   = cnt_hi_q;
      done_lo_d  = done_lo_q & lo_rs & (ena_lo == tcpe_pkg::ENA_ONCE);
      done_hi_d  = done_hi_q & hi_rs & (ena_hi == tcpe_pkg::ENA_ONCE);
      match_lo_d = 1'b0;
      match_hi_d = 1'b0;
      if (tick_q) begin
         if (is64) begin
            if (run64) begin
               if (m64) begin
                  cnt_lo_d   = 32'h0000_0000;
                  cnt_hi_d   = 32'h0000_0000;
                  match_lo_d = 1'b1;
                  done_lo_d  = (ena_lo == tcpe_pkg::ENA_ONCE);
               end else begin
                  cnt_lo_d = cnt64_inc[31:0];
                  cnt_hi_d = cnt64_inc[63:32];
               end
            end
         end else begin
            if (run_lo) begin
               if (m_lo) begin
                  cnt_lo_d   = 32'h0000_0000;
                  match_lo_d = 1'b1;
                  done_lo_d  = (ena_lo == tcpe_pkg::ENA_ONCE);
               end else begin
                  cnt_lo_d = cnt_lo_q + 32'h0000_0001;
               end
            end
            if (go_hi) begin
               if (m_hi) begin
                  cnt_hi_d   = 32'h0000_0000;
                  match_hi_d = 1'b1;
                  done_hi_d  = (ena_hi == tcpe_pkg::ENA_ONCE);
               end else begin
                  cnt_hi_d = cnt_hi_q + 32'h0000_0001;
               end
            end
         end
      end
      // A software write lands on top of whatever the count would have done.
      if (wr_cnt_lo) begin
         cnt_lo_d = pwdata;
      end
      if (wr_cnt_hi) begin
         cnt_hi_d = pwdata;
      end
   end

   // ============================================================
   // Timer input clock enable and suspend synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q  <= 4'h0;
         tick_q <= 1'b0;
      end else if (div_q == tcpe_pkg::CLOCK_RATIO - 4'h1) begin
         div_q  <= 4'h0;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + 4'h1;
         tick_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         susp_meta_q <= 1'b0;
         susp_q      <= 1'b0;
      end else begin
         susp_meta_q <= emu_suspend;
         susp_q      <= susp_meta_q;
      end
   end

   // ============================================================
   // Counter and flag registers
   // Only the hardware reset and a period match clear the counters; the half reset bits merely freeze them.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_lo_q   <= tcpe_pkg::CNT_RST;
         cnt_hi_q   <= tcpe_pkg::CNT_RST;
         done_lo_q  <= 1'b0;
         done_hi_q  <= 1'b0;
         match_lo_q <= 1'b0;
         match_hi_q <= 1'b0;
      end else begin
         cnt_lo_q   <= cnt_lo_d;
         cnt_hi_q   <= cnt_hi_d;
         done_lo_q  <= done_lo_d;
         done_hi_q  <= done_hi_d;
         match_lo_q <= match_lo_d;
         match_hi_q <= match_hi_d;
      end
   end

   // ============================================================
   // Software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prd_lo_q <= tcpe_pkg::PRD_RST;
         prd_hi_q <= tcpe_pkg::PRD_RST;
         ctrl_q   <= tcpe_pkg::CTRL_RST;
         emu_q    <= tcpe_pkg::EMU_RST;
      end else begin
         if (wr_prd_lo) begin
            prd_lo_q <= pwdata;
         end
         if (wr_prd_hi) begin
            prd_hi_q <= pwdata;
         end
         if (wr_ctrl) begin
            ctrl_q <= pwdata[7:0];
         end
         if (wr_emu) begin
            emu_q <= pwdata[1:0];
         end
      end
   end

   // ============================================================
   // APB answer: one wait state, read data and error captured with pready.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= access_start;
         pslverr_q <= access_start & ~hit_any;
         if (access_start & ~pwrite) begin
            prdata_q <= rd_mux;
         end
      end
   end

   assign prdata          = prdata_q;
   assign pready          = pready_q;
   assign pslverr         = pslverr_q;
   assign period_match_lo = match_lo_q;
   assign period_match_hi = match_hi_q;

   // ============================================================
   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   wire no_cnt_wr = ~wr_cnt_lo & ~wr_cnt_hi;

   a_emu_reserved_zero: assert property (
      (access_start && !pwrite && hit_emu) |=>
         (prdata_q[31:20] == 12'h000) && (prdata_q[15:2] == 14'h0000))
      else $error("Reserved emulation bits read nonzero.");

   a_ratio_read_only: assert property (
      (access_start && !pwrite && hit_emu) ##1 (pready_q && hit_emu) |->
         prdata_q[19:16] == tcpe_pkg::CLOCK_RATIO)
      else $error("Clock ratio field changed or misreported.");

   a_free_keeps_counting: assert property (
      (tick_q && susp_q && free_run && is64 && lo_rs && hi_rs && !m64
       && ena_lo == tcpe_pkg::ENA_CONT && no_cnt_wr) |=>
         cnt64 == $past(cnt64) + 64'h0000_0000_0000_0001)
      else $error("Free running timer stopped in suspend.");

   a_hard_stop_holds: assert property (
      (susp_q && !free_run && !soft_stop && no_cnt_wr) |=>
         $stable(cnt_lo_q) && $stable(cnt_hi_q))
      else $error("Timer counted during a hard suspend.");

   a_soft_stop_at_match: assert property (
      (susp_q && !free_run && soft_stop && is64 && m64 && no_cnt_wr) |=>
         $stable(cnt_lo_q) && $stable(cnt_hi_q))
      else $error("Soft stop did not freeze at period.");

   a_counter_reset_zero: assert property (
      $rose(presetn) |-> (cnt_lo_q == 32'h0000_0000) && (cnt_hi_q == 32'h0000_0000))
      else $error("Counters not zero after reset.");

   a_half_reset_holds: assert property (
      (!lo_rs && !wr_cnt_lo) ##1 !wr_cnt_lo |-> $stable(cnt_lo_q))
      else $error("Low counter moved while its reset bit was clear.");

   a_carry_same_tick: assert property (
      (tick_q && is64 && run64 && !m64 && cnt_lo_q == 32'hffff_ffff && no_cnt_wr) |=>
         (cnt_lo_q == 32'h0000_0000) && (cnt_hi_q == $past(cnt_hi_q) + 32'h0000_0001))
      else $error("Low carry did not reach the high half.");

   a_continuous_wraps: assert property (
      (tick_q && is64 && run64 && m64 && ena_lo == tcpe_pkg::ENA_CONT && no_cnt_wr) |=>
         (cnt64 == 64'h0000_0000_0000_0000) && period_match_lo)
      else $error("Continuous timer did not wrap after period match.");

   a_dual_hi_period: assert property (
      (tick_q && mode == tcpe_pkg::MODE_DUAL_UNCH && run_hi && m_hi && !wr_cnt_hi) |=>
         (cnt_hi_q == 32'h0000_0000) && period_match_hi && $stable(prd_hi_q))
      else $error("High half did not match its own period.");

   a_read_counter_hi: assert property (
      (access_start && !pwrite && hit_cnt_hi) |=> prdata_q == $past(cnt_hi_q) && pready_q)
      else $error("High counter read returned wrong data.");

   a_high_half_holds: assert property (
      (!hi_rs && !wr_cnt_hi) |=> $stable(cnt_hi_q))
      else $error("High counter moved while its reset bit was clear.");

   a_idle_low_holds: assert property (
      (!(tick_q && run_lo) && !wr_cnt_lo) |=> $stable(cnt_lo_q))
      else $error("Low counter moved while not enabled.");

   a_once_stays_done: assert property (
      (done_lo_q && ena_lo == tcpe_pkg::ENA_ONCE && !wr_cnt_lo) |=> $stable(cnt_lo_q))
      else $error("One-shot low counter ran again after its match.");

   a_dual_low_alone: assert property (
      (tick_q && mode == tcpe_pkg::MODE_DUAL_UNCH && run_lo && !m_lo && !wr_cnt_lo) |=>
         cnt_lo_q == $past(cnt_lo_q) + 32'h0000_0001)
      else $error("Low half did not count alone in dual mode.");

   a_chain_high_waits: assert property (
      (mode == tcpe_pkg::MODE_DUAL_CH && !m_lo && !wr_cnt_hi) |=> $stable(cnt_hi_q))
      else $error("Chained high half moved without a low match.");

   a_match_all_bits: assert property (
      (period_match_lo && $past(is64)) |-> $past(m64))
      else $error("Period match raised without a full 64-bit match.");

   a_pready_single: assert property (
      pready_q |=> !pready_q)
      else $error("Bus answer lasted more than one cycle.");

   a_unmapped_error: assert property (
      (access_start && !hit_any) |=> pslverr_q && pready_q)
      else $error("Unmapped access answered without an error.");

   a_period_write_lands: assert property (
      (access_done && pwrite && hit_prd_lo) |=> prd_lo_q == $past(pwdata))
      else $error("Low period write did not land.");

   a_counter_write_lands: assert property (
      wr_cnt_hi |=> cnt_hi_q == $past(pwdata))
      else $error("High counter write did not land.");

endmodule // tcpe_timer_regs

// >>> testbench/tcpe_timer_regs_tb.sv
`timescale 1ns/1ps
module tcpe_timer_regs_tb;
   // ============================================================
   // Signals
   logic        pclk;
   logic        presetn;
   logic [11:0] paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        emu_suspend;
   logic        period_match_lo;
   logic        period_match_hi;
   int          mismatches = 0;
   int          checked    = 0;
   logic [31:0] rd;
   logic        er;
   logic [31:0] v;
   logic [31:0] q;
   logic [31:0] vals [4];
   logic [11:0] adr [4];
   int          n;

   tcpe_timer_regs tcpe_timer_regs_i (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .emu_suspend(emu_suspend), .period_match_lo(period_match_lo),
      .period_match_hi(period_match_hi));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // ============================================================
   // Helpers
   task automatic print_verdict();
      if (mismatches == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(string nm, logic [63:0] s, logic [63:0] e);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", nm, e, s);
      end
   endtask

   // One APB transfer; a dead slave is left to the watchdog rather than guessed at here.
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(logic [11:0] a, logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(string nm, logic [11:0] a, logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, rd, e);
   endtask

   function automatic logic [31:0] ctl(logic [1:0] m, logic [1:0] rs, logic [1:0] el,
                                       logic [1:0] eh);
      return {24'h00_0000, eh, el, rs, m};
   endfunction

   function automatic logic [31:0] emu_exp(logic [31:0] w);
      return {12'h000, tcpe_pkg::CLOCK_RATIO, 14'h0000, w[1:0]};
   endfunction

   task automatic pulse(logic hi, output int k);
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while ((hi ? period_match_hi : period_match_lo) !== 1'b1 && k < 2000);
   endtask

   task automatic gap(logic hi, output int c);
      int k;
      pulse(hi, k);
      pulse(hi, c);
   endtask

   // Counting is stopped before the counters are loaded so the start point is known.
   task automatic run(logic [1:0] m, logic [31:0] cl, logic [31:0] pl, logic [31:0] ph);
      wr(tcpe_pkg::OFF_CTRL, ctl(m, 2'b00, tcpe_pkg::ENA_OFF, tcpe_pkg::ENA_OFF));
      wr(tcpe_pkg::OFF_CNT_LO, cl);
      wr(tcpe_pkg::OFF_CNT_HI, 32'h0000_0000);
      wr(tcpe_pkg::OFF_PRD_LO, pl);
      wr(tcpe_pkg::OFF_PRD_HI, ph);
      wr(tcpe_pkg::OFF_CTRL, ctl(m, 2'b11, tcpe_pkg::ENA_CONT, tcpe_pkg::ENA_CONT));
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      print_verdict();
   end

   // ============================================================
   // Tests
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      emu_suspend = 1'b0;
      adr = '{tcpe_pkg::OFF_CNT_LO, tcpe_pkg::OFF_CNT_HI, tcpe_pkg::OFF_PRD_LO,
              tcpe_pkg::OFF_PRD_HI};
      v = $urandom(32'h708e);
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdchk("counter_low", tcpe_pkg::OFF_CNT_LO, 32'h0000_0000);
      chk("mapped_err", er, 1'b0);
      rdchk("counter_high", tcpe_pkg::OFF_CNT_HI, 32'h0000_0000);
      rdchk("ratio_reset", tcpe_pkg::OFF_EMU_RATIO, emu_exp(0));
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 32'hffff_ffff : $urandom();
         wr(tcpe_pkg::OFF_EMU_RATIO, v);
         rdchk("emulation_clock_ratio", tcpe_pkg::OFF_EMU_RATIO, emu_exp(v));
      end
      apb(1'b0, 12'h0f0, 32'h0000_0000);
      chk("unmapped_err", er, 1'b1);
      chk("unmapped_data", rd, 32'h0000_0000);
      // Halves are written while held, so every word must read back untouched.
      for (int i = 0; i < 4; i++) begin
         vals[i] = $urandom();
         wr(adr[i], vals[i]);
      end
      for (int i = 0; i < 4; i++) rdchk("half_word", adr[i], vals[i]);
      wr(tcpe_pkg::OFF_CTRL, ctl(tcpe_pkg::MODE_DUAL_UNCH, 2'b01, tcpe_pkg::ENA_CONT,
                                 tcpe_pkg::ENA_CONT));
      repeat (10) @(posedge pclk);
      rdchk("held_high", tcpe_pkg::OFF_CNT_HI, vals[1]);
      q = $urandom_range(12, 2);
      run(tcpe_pkg::MODE_GP64, 0, q, 0);
      gap(1'b0, n);
      chk("gp64_gap", n, q + 1);
      run(tcpe_pkg::MODE_WDOG, 0, q, 0);
      gap(1'b0, n);
      chk("wdog_gap", n, q + 1);
      v = $urandom_range(5, 2);
      q = $urandom_range(5, 2);
      run(tcpe_pkg::MODE_DUAL_UNCH, 0, v, q);
      gap(1'b0, n);
      chk("dual_lo_gap", n, v + 1);
      gap(1'b1, n);
      chk("dual_hi_gap", n, q + 1);
      run(tcpe_pkg::MODE_DUAL_CH, 0, v, q);
      gap(1'b1, n);
      chk("chain_gap", n, (v + 1) * (q + 1));
      // A match here is only possible if the low carry reached the high half.
      run(tcpe_pkg::MODE_GP64, 32'hffff_fff0, 32'h0000_0002, 32'h0000_0001);
      pulse(1'b0, n);
      chk("carry_match", n < 40, 1'b1);
      rdchk("carry_wrap", tcpe_pkg::OFF_CNT_HI, 32'h0000_0000);
      // A one-shot count wraps once and then must sit at zero.
      q = $urandom_range(9, 2);
      run(tcpe_pkg::MODE_GP64, 0, q, 0);
      wr(tcpe_pkg::OFF_CTRL, ctl(tcpe_pkg::MODE_GP64, 2'b11, tcpe_pkg::ENA_ONCE,
                                 tcpe_pkg::ENA_OFF));
      pulse(1'b0, n);
      repeat (12) @(posedge pclk);
      rdchk("once_hold", tcpe_pkg::OFF_CNT_LO, 32'h0000_0000);
      wr(tcpe_pkg::OFF_EMU_RATIO, 32'h0000_0000);
      run(tcpe_pkg::MODE_GP64, 0, 32'h0000_03e8, 0);
      emu_suspend <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b0, tcpe_pkg::OFF_CNT_LO, 32'h0000_0000);
      v = rd;
      repeat (8) @(posedge pclk);
      rdchk("hard_stop", tcpe_pkg::OFF_CNT_LO, v);
      emu_suspend <= 1'b0;
      repeat (6) @(posedge pclk);
      apb(1'b0, tcpe_pkg::OFF_CNT_LO, 32'h0000_0000);
      chk("resume", rd != v, 1'b1);
      wr(tcpe_pkg::OFF_EMU_RATIO, 32'h0000_0002);
      emu_suspend <= 1'b1;
      run(tcpe_pkg::MODE_GP64, 0, 32'h0000_0014, 0);
      repeat (40) @(posedge pclk);
      rdchk("soft_stop", tcpe_pkg::OFF_CNT_LO, 32'h0000_0014);
      wr(tcpe_pkg::OFF_EMU_RATIO, 32'h0000_0001);
      q = $urandom_range(9, 2);
      run(tcpe_pkg::MODE_GP64, 0, q, 0);
      gap(1'b0, n);
      chk("free_run", n, q + 1);
      emu_suspend <= 1'b0;
      print_verdict();
   end
endmodule // tcpe_timer_regs_tb
